// >>> design/dhi_pkg.sv
// package for the display host interface front end
// assumes one 25 MHz core clock; host pins are asynchronous to it
package dhi_pkg;
  localparam logic [2:0] DHI_SEL_6800 = 3'h4;
  localparam logic [2:0] DHI_SEL_8080 = 3'h6;
  localparam logic [2:0] DHI_SEL_SPI4 = 3'h0;
  localparam logic [2:0] DHI_SEL_SPI3 = 3'h1;
  localparam logic [2:0] DHI_SEL_TWI = 3'h2;
  localparam logic [3:0] DHI_BITS_SPI4 = 4'h8;
  localparam logic [3:0] DHI_BITS_SPI3 = 4'h9;
  localparam int DHI_FIFO_DEPTH = 4;
  localparam int DHI_FIFO_WIDTH = 9;
  typedef enum logic [2:0] {DHI_M_P6800, DHI_M_P8080, DHI_M_SPI4, DHI_M_SPI3,
    DHI_M_OFF} dhi_mode_t;
endpackage

// >>> design/dhi_fifo.sv
// small valid/ready fifo for the write stream
// assumes both sides on one clock
`timescale 1ns/1ps
module dhi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dhi_fifo_st_t;
  dhi_fifo_st_t st_ff;
  dhi_fifo_st_t nxt_st;
  logic push;
  logic pop;
  assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_ff.cnt != '0;
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop)
      nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule

// >>> design/dhi_top.sv
// host port front end: parallel 6800/8080 and 3/4-wire serial writes
// assumes all host pins are asynchronous to REF_CLK; data lines split in/out/oe
`timescale 1ns/1ps
module dhi_top
  import dhi_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HARDWARE_CLEAR_N,
  input wire logic PORT_SELECT_BIT0,
  input wire logic PORT_SELECT_BIT1,
  input wire logic PORT_SELECT_BIT2,
  input wire logic CS_N,
  input wire logic DATA_COMMAND_SELECT,
  input wire logic STROBE_E_RD_N,
  input wire logic RW_WR_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic SER_CLK,
  input wire logic SER_IN,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic [7:0] RAM_RD_DATA,
  output logic RAM_RD_REQ,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic [7:0] WR_DATA,
  output logic WR_IS_RAM,
  output logic MODE_TWI,
  output logic BYTE_DROPPED
);
  // 3-stage synchronisers for host pins: cs, dc, e/rd, rw/wr, sclk, sin, clr
  localparam int NS = 7;
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] stab;
    logic [7:0] din2;
    logic [7:0] din3;
    logic [2:0] strap;
    logic strap_done;
    dhi_mode_t mode;
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] rd_latch;
    logic [7:0] rd_pipe;
    logic oe;
    logic rd_req;
    logic in_valid;
    logic [8:0] in_word;
    logic dropped;
    logic twi;
  } dhi_st_t;
  dhi_st_t st_ff;
  dhi_st_t nxt_st;
  logic [NS-1:0] raw;
  logic cs_n;
  logic dc;
  logic e_rd;
  logic rw_wr;
  logic sclk;
  logic sin;
  logic clr_n;
  logic e_rd_prev;
  logic rw_wr_prev;
  logic sclk_prev;
  logic fifo_ready;
  logic fifo_valid;
  logic [8:0] fifo_data;
  assign raw = {HARDWARE_CLEAR_N, SER_IN, SER_CLK, RW_WR_N, STROBE_E_RD_N,
                DATA_COMMAND_SELECT, CS_N};
  // a change is believed only once stages two and three agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.din2 = DATA_IN;
    nxt_st.din3 = st_ff.din2;
    for (int i = 0; i < NS; i++)
      if (st_ff.s2[i] == st_ff.s3[i])
        nxt_st.stab[i] = st_ff.s3[i];
    {clr_n, sin, sclk, rw_wr, e_rd, dc, cs_n} = nxt_st.stab;
    {sclk_prev, rw_wr_prev, e_rd_prev} = {st_ff.stab[4], st_ff.stab[3], st_ff.stab[2]};
    nxt_st.in_valid = st_ff.in_valid && !fifo_ready;
    nxt_st.rd_req = 1'b0;
    nxt_st.dropped = 1'b0;
    // straps caught once after reset release
    if (!st_ff.strap_done)
    begin
      // bit2 leftmost, so the 3-wire strap (only bit0 set) decodes as 3'h1
      nxt_st.strap = {PORT_SELECT_BIT2, PORT_SELECT_BIT1, PORT_SELECT_BIT0};
      nxt_st.strap_done = 1'b1;
    end
    case (st_ff.strap)
      DHI_SEL_6800: nxt_st.mode = DHI_M_P6800;
      DHI_SEL_8080: nxt_st.mode = DHI_M_P8080;
      DHI_SEL_SPI4: nxt_st.mode = DHI_M_SPI4;
      DHI_SEL_SPI3: nxt_st.mode = DHI_M_SPI3;
      default: nxt_st.mode = DHI_M_OFF;
    endcase
    nxt_st.twi = st_ff.strap == DHI_SEL_TWI;
    case (st_ff.mode)
      DHI_M_P6800:
      begin
        // e high with rw high drives the bus; falling e ends the cycle
        nxt_st.oe = !cs_n && e_rd && rw_wr;
        if (!cs_n && e_rd && !e_rd_prev && rw_wr)
          nxt_st.rd_latch = dc ? st_ff.rd_pipe : STATUS_BYTE;
        if (!cs_n && !e_rd && e_rd_prev)
        begin
          if (rw_wr && dc)
          begin
            nxt_st.rd_pipe = RAM_RD_DATA;
            nxt_st.rd_req = 1'b1;
          end
          else if (!rw_wr)
          begin
            nxt_st.in_word = {dc, st_ff.din3};
            nxt_st.dropped = st_ff.in_valid && !fifo_ready;
            nxt_st.in_valid = 1'b1;
          end
        end
      end
      DHI_M_P8080:
      begin
        nxt_st.oe = !cs_n && !e_rd;
        if (!cs_n && !e_rd && e_rd_prev)
          nxt_st.rd_latch = dc ? st_ff.rd_pipe : STATUS_BYTE;
        if (!cs_n && e_rd && !e_rd_prev && dc)
        begin
          nxt_st.rd_pipe = RAM_RD_DATA;
          nxt_st.rd_req = 1'b1;
        end
        if (!cs_n && rw_wr && !rw_wr_prev)
        begin
          nxt_st.in_word = {dc, st_ff.din3};
          nxt_st.dropped = st_ff.in_valid && !fifo_ready;
          nxt_st.in_valid = 1'b1;
        end
      end
      DHI_M_SPI4, DHI_M_SPI3:
      begin
        nxt_st.oe = 1'b0;
        if (cs_n)
        begin
          nxt_st.shreg = '0;
          nxt_st.bitcnt = '0;
        end
        else if (sclk && !sclk_prev)
        begin
          nxt_st.shreg = {st_ff.shreg[7:0], sin};
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          if (st_ff.mode == DHI_M_SPI4 && nxt_st.bitcnt == DHI_BITS_SPI4)
          begin
            nxt_st.in_word = {dc, nxt_st.shreg[7:0]};
            nxt_st.bitcnt = '0;
            nxt_st.dropped = st_ff.in_valid && !fifo_ready;
            nxt_st.in_valid = 1'b1;
          end
          else if (st_ff.mode == DHI_M_SPI3 && nxt_st.bitcnt == DHI_BITS_SPI3)
          begin
            nxt_st.in_word = nxt_st.shreg;
            nxt_st.bitcnt = '0;
            nxt_st.dropped = st_ff.in_valid && !fifo_ready;
            nxt_st.in_valid = 1'b1;
          end
        end
      end
      default:
        nxt_st.oe = 1'b0;
    endcase
    // pin clear resets serial count, read pipe and latch, oe and the pending write; fifo, straps and mode are kept
    if (!clr_n)
    begin
      nxt_st.shreg = '0;
      nxt_st.bitcnt = '0;
      nxt_st.rd_pipe = '0;
      nxt_st.rd_latch = '0;
      nxt_st.oe = 1'b0;
      nxt_st.in_valid = 1'b0;
    end
  end
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_ff <= '0;
      st_ff.s1 <= 7'h7f;
      st_ff.s2 <= 7'h7f;
      st_ff.s3 <= 7'h7f;
      st_ff.stab <= 7'h7f;
      st_ff.mode <= DHI_M_OFF;
    end
    else
      st_ff <= nxt_st;
  end
  // fifo absorbs bursts; the sink stalls via WR_READY
  dhi_fifo #(.WIDTH(DHI_FIFO_WIDTH), .DEPTH(DHI_FIFO_DEPTH)) u_fifo (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .in_valid(st_ff.in_valid),
    .in_ready(fifo_ready),
    .in_data(st_ff.in_word),
    .out_valid(fifo_valid),
    .out_ready(WR_READY || !WR_VALID),
    .out_data(fifo_data)
  );
  // output stage registered so every port leaves a flip-flop
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      WR_VALID <= 1'b0;
      WR_DATA <= 8'h00;
      WR_IS_RAM <= 1'b0;
    end
    else if (WR_READY || !WR_VALID)
    begin
      WR_VALID <= fifo_valid;
      WR_DATA <= fifo_data[7:0];
      WR_IS_RAM <= fifo_data[8];
    end
  end
  assign DATA_OUT = st_ff.rd_latch;
  assign DATA_OE = st_ff.oe;
  assign RAM_RD_REQ = st_ff.rd_req;
  assign MODE_TWI = st_ff.twi;
  assign BYTE_DROPPED = st_ff.dropped;

  AST_SPI_CLR: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st_ff.mode inside {DHI_M_SPI4, DHI_M_SPI3}) && st_ff.stab[0] |=> st_ff.bitcnt == 4'h0)
    else $error("serial counter not cleared by chip select");
  AST_SER_NO_OE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st_ff.mode inside {DHI_M_SPI4, DHI_M_SPI3}) |=> !DATA_OE)
    else $error("data bus driven in serial mode");
  AST_CNT4: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st_ff.mode == DHI_M_SPI4 |-> st_ff.bitcnt < DHI_BITS_SPI4)
    else $error("4-wire counter overran");
  AST_CNT3: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st_ff.mode == DHI_M_SPI3 |-> st_ff.bitcnt < DHI_BITS_SPI3)
    else $error("3-wire counter overran");
  // oe was registered from the synchronised pins that stab now holds, so same cycle
  AST_OE8080: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st_ff.mode == DHI_M_P8080 && st_ff.stab[0] |-> !DATA_OE)
    else $error("bus driven without chip select");
  AST_OE6800: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st_ff.mode == DHI_M_P6800 && !st_ff.stab[3] |-> !DATA_OE)
    else $error("bus driven during 6800 write");
  AST_CLR: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !st_ff.stab[6] |=> st_ff.bitcnt == 4'h0 && st_ff.rd_pipe == 8'h00)
    else $error("clear pin did not idle the port");
  AST_WR_HOLD: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA) && $stable(WR_IS_RAM))
    else $error("write stream dropped under stall");
endmodule

// >>> verif/dhi_host_model.sv
// host model: drives parallel strobes or the serial link
// assumes the bench calls its tasks; merges the data bus level
`timescale 1ns/1ps
module dhi_host_model
(
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic cs_n,
  output logic dc,
  output logic e_rd_n,
  output logic rw_wr_n,
  output logic [7:0] data_in,
  output logic ser_clk,
  output logic ser_in
);
  logic [7:0] hd = 8'h00;
  logic hoe = 1'b1;
  // released bus shows the inverse, so a stale byte cannot pass
  assign data_in = data_oe ? data_out : (hoe ? hd : ~hd);
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic idle(bit m80);
    cs_n = 1'b1;
    dc = 1'b0;
    e_rd_n = m80;
    rw_wr_n = 1'b1;
    ser_clk = 1'b0;
    ser_in = 1'b0;
  endtask
  task automatic pwr(bit m80, bit cs, bit dcv, logic [7:0] d);
    cs_n = cs;
    dc = dcv;
    hd = d;
    rw_wr_n = 1'b0;
    e_rd_n = 1'b1;
    cyc(10);
    if (m80)
      rw_wr_n = 1'b1;
    else
      e_rd_n = 1'b0;
    cyc(10);
    idle(m80);
    cyc(1);
  endtask
  task automatic prd(bit m80, bit cs, bit dcv, output logic [7:0] d, output logic oe);
    cs_n = cs;
    dc = dcv;
    hoe = 1'b0;
    e_rd_n = !m80;
    cyc(10);
    d = data_out;
    oe = data_oe;
    e_rd_n = m80;
    cyc(10);
    hoe = 1'b1;
    cs_n = 1'b1;
    cyc(1);
  endtask
  // clock stands low outside frames
  task automatic spi(int n, logic [8:0] w, bit dcv);
    cs_n = 1'b0;
    dc = dcv;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_in = w[i];
      cyc(4);
      ser_clk = 1'b1;
      cyc(4);
      ser_clk = 1'b0;
    end
    cyc(1);
    ser_in = ~ser_in;
    cyc(1);
  endtask
endmodule

// >>> verif/tb_dhi_top.sv
// bench: host model drives the port, a watcher scores the write stream
// assumes one REF_CLK domain; straps change only across a reset
`timescale 1ns/1ps
module tb_dhi_top;
  logic ref_clk = 0, rstn = 0, clr_n = 1, ps0 = 0, ps1 = 0, ps2 = 0, rdy = 0;
  logic [7:0] stat = 8'h00, ramd = 8'h00, din, dout, wd, pipe, rd;
  logic cs_n, dc, e, rw, sck, si, doe, rreq, wv, wram, twi, drop, oe;
  int failures = 0, comparisons = 0, cycles = 0, reqs = 0, exp_reqs = 0, drops = 0;
  bit ser = 0;
  logic [8:0] expq[$];
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  dhi_top i_dhi_top (.REF_CLK(ref_clk), .RSTN(rstn), .HARDWARE_CLEAR_N(clr_n),
    .PORT_SELECT_BIT0(ps0), .PORT_SELECT_BIT1(ps1), .PORT_SELECT_BIT2(ps2),
    .CS_N(cs_n), .DATA_COMMAND_SELECT(dc), .STROBE_E_RD_N(e), .RW_WR_N(rw),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .SER_CLK(sck), .SER_IN(si),
    .STATUS_BYTE(stat), .RAM_RD_DATA(ramd), .RAM_RD_REQ(rreq), .WR_VALID(wv),
    .WR_READY(rdy), .WR_DATA(wd), .WR_IS_RAM(wram), .MODE_TWI(twi), .BYTE_DROPPED(drop));
  dhi_host_model i_dhi_host_model (.clk(ref_clk), .data_out(dout), .data_oe(doe),
    .cs_n(cs_n), .dc(dc), .e_rd_n(e), .rw_wr_n(rw), .data_in(din), .ser_clk(sck), .ser_in(si));
  task automatic check(logic [8:0] seen, logic [8:0] exp, string msg);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
    if (rreq === 1'b1)
      reqs++;
    if (drop === 1'b1)
      drops++;
    if (wv === 1'b1 && rdy === 1'b1)
    begin
      if (expq.size() == 0)
        check({8'h00, wv}, 9'h000, "extra write");
      else
        check({wram, wd}, expq.pop_front(), "stream");
    end
  end
  // random stalls, one cycle in four, make the output stage hold WR_VALID against a low WR_READY
  always @(posedge ref_clk)
  begin
    #1;
    if (rstn)
      rdy = ($urandom % 4) != 0;
  end
  task automatic cyc(int n);
    i_dhi_host_model.cyc(n);
  endtask
  task automatic drain();
    for (int i = 0; i < 400 && expq.size() != 0; i++)
      cyc(1);
    check(9'(expq.size()), 9'h000, "drain");
    check(9'(drops), 9'h000, "byte dropped");
  endtask
  task automatic rst(bit b0, bit b1, bit b2, bit m80);
    drain();
    rstn = 0;
    {ps0, ps1, ps2} = {b0, b1, b2};
    ser = !b1 && !b2;
    i_dhi_host_model.idle(m80);
    pipe = 8'h00;
    cyc(4);
    rstn = 1;
    cyc(4);
    check({8'h00, twi}, {8'h00, b1 & !b0 & !b2}, "two-wire strap");
  endtask
  task automatic w(bit m80, bit cs, bit dcv, logic [7:0] d);
    if (!cs)
      expq.push_back({dcv, d});
    i_dhi_host_model.pwr(m80, cs, dcv, d);
  endtask
  task automatic r(bit m80, bit cs, bit dcv);
    ramd = 8'($urandom);
    i_dhi_host_model.prd(m80, cs, dcv, rd, oe);
    // serial modes have no read path, so the bus must stay released
    check({8'h00, oe}, {8'h00, !cs && !ser}, "drive on read");
    if (!cs && !ser)
      check({1'b0, rd}, {1'b0, dcv ? pipe : stat}, "read data");
    if (dcv && !cs && !ser)
    begin
      pipe = ramd;
      exp_reqs++;
    end
    check(9'(reqs), 9'(exp_reqs), "ram read request");
    check({8'h00, doe}, 9'h000, "released after read");
  endtask
  task automatic s(int n, logic [8:0] v, bit dcv);
    expq.push_back(n == 9 ? v : {dcv, v[7:0]});
    i_dhi_host_model.spi(n, v, dcv);
  endtask
  task automatic hw_clear();
    drain();
    clr_n = 0;
    cyc(8);
    clr_n = 1;
    cyc(8);
  endtask
  initial
  begin
    void'($urandom(15));
    for (int m = 0; m < 2; m++)
    begin
      rst(0, m[0], 1, m[0]);
      stat = 8'($urandom);
      for (int i = 0; i < 6; i++)
        w(m[0], 0, i[0], 8'($urandom));
      w(m[0], 1, 1, 8'h5a);
      r(m[0], 1, 1);
      r(m[0], 0, 1);
      r(m[0], 0, 1);
      r(m[0], 0, 0);
      r(m[0], 0, 1);
      hw_clear();
      pipe = 8'h00;
      r(m[0], 0, 1);
      $display("test parallel %0d done", m);
    end
    rst(0, 0, 0, 0);
    for (int i = 0; i < 4; i++)
      s(8, 9'($urandom), i[0]);
    i_dhi_host_model.spi(5, 9'h01f, 1);
    i_dhi_host_model.idle(0);
    cyc(8);
    s(8, 9'h0a5, 0);
    r(0, 0, 1);
    $display("test 4-wire done");
    rst(1, 0, 0, 0);
    for (int i = 0; i < 4; i++)
      s(9, 9'($urandom), 0);
    i_dhi_host_model.spi(4, 9'h00f, 0);
    hw_clear();
    s(9, 9'h1c3, 0);
    $display("test 3-wire done");
    rst(0, 1, 0, 0);
    $display("test two-wire done");
    drain();
    wrap_up();
  end
endmodule
